// [rtl/return_spread_scramble.sv]
// Spreading, gain weighting, scrambling and shaping of the dedicated channels.
// Contract
// R1: Bit zero maps to +1, bit one maps to -1, before spreading.
// R2: Data uses the in-phase code, control uses the quadrature code.
// R3: Control chips are weighted by a gain chosen by a 4-bit value.
// R4: Gain v gives ratio v/15; zero switches control branch off.
// R5: Both branches form one complex stream scrambled, aligned to frames.
// R6: All dedicated channels on one carrier share one scrambling sequence.
// R7: Code picked by spreading factor and index below it; root code is +1.
// R8: Leftmost code element goes out first in time.
// R9: Scrambling code is a short code repeating every 256 chips.
// R10: Code number is 24 bits split into low, middle and high bytes.
// R11: Quaternary z is a plus twice b plus twice d, modulo 4.
// R12: Initial a, b and d are loaded from code number bits.
// R13: a recursion uses taps three, five, six, seven and eight back.
// R14: b recursion uses taps one, three, seven and eight back.
// R15: d recursion uses taps one, three, four and eight back.
// R16: Sequence extended to 256 chips by repeating chip zero.
// R17: Quaternary values map to first and second binary sequences by table.
// R18: Complex chip uses first chip, alternating phase, second chip at even index.
// R19: Real part drives the in-phase rail, imaginary the quadrature rail.
// R20: Chips are shaped by root raised cosine with roll-off 0.22.
// R21: Each code c spawns children c,c and c,-c at double length.
// R22: Generators reload and chip index clears at every frame start.
//
// Our own choices: register access over Wishbone and the placing of the registers.
module return_spread_scramble (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        frame_start_i,
    input  wire logic        data_bit_i,
    input  wire logic        ctrl_bit_i,
    output logic             bit_take_o,
    output logic signed [15:0] tx_i_o,
    output logic signed [15:0] tx_q_o,
    output logic             tx_valid_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Register file.

    spread_pkg::cfg_s cfg_q;
    spread_pkg::cfg_s cfg_d;
    logic [7:0]  ki_q;
    logic [7:0]  ki_d;
    logic [7:0]  kq_q;
    logic [7:0]  kq_d;
    logic [23:0] num_q;
    logic [23:0] num_d;
    logic        ack_d;
    logic [31:0] dat_d;
    logic        wr;
    logic [3:0]  sf_wr;

    logic [1:0]  div_q;
    logic [1:0]  div_d;
    logic        stb_q;
    logic        stb_d;
    logic        take_d;
    logic [7:0]  idx_q;
    logic [7:0]  idx_d;
    logic [7:0]  pos_q;
    logic [7:0]  pos_d;
    logic        dhold_q;
    logic        dhold_d;
    logic        chold_q;
    logic        chold_d;
    logic        c2h_q;
    logic        c2h_d;
    spread_pkg::chip_s chip_q;
    spread_pkg::chip_s chip_d;

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign sf_wr = (wb_dat_i[spread_pkg::SF_POS +: 4] > spread_pkg::SF_MAX)
                 ? spread_pkg::SF_MAX : wb_dat_i[spread_pkg::SF_POS +: 4];

    always_comb begin
        cfg_d = cfg_q;
        ki_d  = ki_q;
        kq_d  = kq_q;
        num_d = num_q;
        ack_d = wb_cyc_i && wb_stb_i && !wb_ack_o;
        dat_d = 32'h00000000;
        if (wr && wb_adr_i == spread_pkg::ADR_CTRL) begin
            if (wb_sel_i[0]) begin
                cfg_d.en   = wb_dat_i[spread_pkg::EN_POS];
                cfg_d.gain = wb_dat_i[spread_pkg::GAIN_POS +: 4];
            end
            if (wb_sel_i[1]) begin
                cfg_d.sf_log2 = sf_wr;
            end
        end
        if (wr && wb_adr_i == spread_pkg::ADR_CODE) begin
            if (wb_sel_i[0]) begin
                ki_d = wb_dat_i[spread_pkg::KI_POS +: 8];
            end
            if (wb_sel_i[1]) begin
                kq_d = wb_dat_i[spread_pkg::KQ_POS +: 8];
            end
        end
        if (wr && wb_adr_i == spread_pkg::ADR_SCR) begin
            for (int y = 0; y < 3; y++) begin
                if (wb_sel_i[y]) begin
                    num_d[8 * y +: 8] = wb_dat_i[8 * y +: 8]; // R10
                end
            end
        end
        if (ack_d) begin
            case (wb_adr_i)
                spread_pkg::ADR_CTRL: begin
                    dat_d[spread_pkg::EN_POS]        = cfg_q.en;
                    dat_d[spread_pkg::GAIN_POS +: 4] = cfg_q.gain;
                    dat_d[spread_pkg::SF_POS +: 4]   = cfg_q.sf_log2;
                end
                spread_pkg::ADR_CODE: begin
                    dat_d[spread_pkg::KI_POS +: 8] = ki_q;
                    dat_d[spread_pkg::KQ_POS +: 8] = kq_q;
                end
                spread_pkg::ADR_SCR: begin
                    dat_d[23:0] = num_q;
                end
                spread_pkg::ADR_STAT: begin
                    dat_d[spread_pkg::IDX_POS +: 8] = idx_q;
                    dat_d[spread_pkg::PHS_POS +: 8] = pos_q;
                    dat_d[spread_pkg::RUN_POS]      = cfg_q.en;
                end
                default: begin
                    dat_d = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q    <= '{en: spread_pkg::EN_RST, gain: spread_pkg::GAIN_RST, sf_log2: spread_pkg::SF_RST};
            ki_q     <= spread_pkg::K_RST;
            kq_q     <= spread_pkg::K_RST;
            num_q    <= spread_pkg::NUM_RST;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            cfg_q    <= cfg_d;
            ki_q     <= ki_d;
            kq_q     <= kq_d;
            num_q    <= num_d;
            wb_ack_o <= ack_d;
            wb_dat_o <= dat_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Chip timing and symbol position.

    logic       restart;
    logic       last_pos;
    logic [7:0] sf_mask;

    assign restart  = frame_start_i || !cfg_q.en;
    assign sf_mask  = 8'((9'h001 << cfg_q.sf_log2) - 9'h001);
    assign last_pos = pos_q == sf_mask;

    always_comb begin
        div_d  = div_q;
        stb_d  = 1'b0;
        idx_d  = idx_q;
        pos_d  = pos_q;
        take_d = 1'b0;
        if (restart) begin
            div_d = 2'h0; // R22
            idx_d = 8'h00; // R22
            pos_d = 8'h00; // R5
        end else begin
            div_d  = (div_q == spread_pkg::CHIP_CLKS - 2'h1) ? 2'h0 : div_q + 2'h1;
            stb_d  = div_q == spread_pkg::CHIP_CLKS - 2'h1; // R2
            take_d = stb_d && pos_d == 8'h00;
            if (stb_q) begin
                idx_d = idx_q + 8'h01; // R9
                pos_d = last_pos ? 8'h00 : pos_q + 8'h01;
                take_d = stb_d && pos_d == 8'h00;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q      <= 2'h0;
            stb_q      <= 1'b0;
            idx_q      <= 8'h00;
            pos_q      <= 8'h00;
            bit_take_o <= 1'b0;
        end else begin
            div_q      <= div_d;
            stb_q      <= stb_d;
            idx_q      <= idx_d;
            pos_q      <= pos_d;
            bit_take_o <= take_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Orthogonal tree codes.

    logic [7:0] kri;
    logic [7:0] krq;
    logic [7:0] rev_i;
    logic [7:0] rev_q;
    logic       code_i_neg;
    logic       code_q_neg;

    for (genvar b = 0; b < 8; b++) begin : g_rev
        assign kri[b] = ki_q[7 - b];
        assign krq[b] = kq_q[7 - b];
    end

    assign rev_i = kri >> (4'h8 - cfg_q.sf_log2); // R7
    assign rev_q = krq >> (4'h8 - cfg_q.sf_log2); // R7
    assign code_i_neg = ^(pos_q & rev_i); // R21 R8
    assign code_q_neg = ^(pos_q & rev_q); // R21 R8

    ////////////////////////////////////////////////////////////////////////////
    // Scrambling code.

    logic scr_load;
    logic c1n;
    logic c2n;
    logic c2e;

    assign scr_load = restart || (stb_q && idx_q == spread_pkg::IDX_LAST); // R22 R9

    scramble_gen u_scr (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .load_i   (scr_load),
        .step_i   (stb_q),
        .last_i   (idx_q == spread_pkg::IDX_LAST),
        .num_i    (num_q), // R6
        .c1_neg_o (c1n),
        .c2_neg_o (c2n)
    );

    assign c2e = idx_q[0] ? c2h_q : c2n; // R18

    ////////////////////////////////////////////////////////////////////////////
    // Mapping, spreading, weighting and complex scrambling.

    logic              dsym;
    logic              csym;
    logic              i_neg;
    logic              q_neg;
    logic              cr_neg;
    logic              ci_neg;
    logic signed [5:0] ival;
    logic signed [5:0] qval;
    logic signed [5:0] gmag;

    assign dsym = (pos_q == 8'h00) ? data_bit_i : dhold_q;
    assign csym = (pos_q == 8'h00) ? ctrl_bit_i : chold_q;
    assign i_neg = dsym ^ code_i_neg; // R1 R2
    assign q_neg = csym ^ code_q_neg; // R1 R2
    assign gmag = 6'(cfg_q.gain);
    assign ival = i_neg ? -spread_pkg::AMP_FULL : spread_pkg::AMP_FULL;
    assign qval = q_neg ? -gmag : gmag; // R3 R4
    assign cr_neg = c1n ^ c2e; // R18
    assign ci_neg = cr_neg ^ idx_q[0]; // R18

    always_comb begin
        dhold_d = dhold_q;
        chold_d = chold_q;
        c2h_d   = c2h_q;
        chip_d  = '0;
        if (stb_q) begin
            dhold_d = dsym;
            chold_d = csym;
            if (!idx_q[0]) begin
                c2h_d = c2n;
            end
            chip_d.re = (cr_neg ? -ival : ival) - (ci_neg ? -qval : qval); // R5
            chip_d.im = (ci_neg ? -ival : ival) + (cr_neg ? -qval : qval); // R5
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dhold_q <= 1'b0;
            chold_q <= 1'b0;
            c2h_q   <= 1'b0;
            chip_q  <= '0;
        end else begin
            dhold_q <= dhold_d;
            chold_q <= chold_d;
            c2h_q   <= c2h_d;
            chip_q  <= chip_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pulse shaping.

    rrc_shaper u_rrc (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .en_i    (cfg_q.en),
        .chip_i  (chip_q), // R19
        .i_o     (tx_i_o),
        .q_o     (tx_q_o),
        .valid_o (tx_valid_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_take_align: assert property (bit_take_o |-> stb_q && pos_q == 8'h00) // R2
        else $error("bit take not at symbol start");
    a_map_zero: assert property (stb_q && pos_q == 8'h00 && !data_bit_i && !code_i_neg |-> ival > 0) // R1
        else $error("zero bit not mapped to plus one");
    a_gain_off: assert property (stb_q && cfg_q.gain == 4'h0 |-> qval == 6'sh00) // R4
        else $error("control branch not off at gain zero");
    a_gain_full: assert property (stb_q && cfg_q.gain == 4'hF |-> qval == ival || qval == -ival) // R3
        else $error("full gain not equal to data amplitude");
    a_idx_reload: assert property (stb_q && idx_q == 8'hFF && cfg_q.en |-> scr_load ##1 idx_q == 8'h00) // R9
        else $error("scrambler not reloaded at period end");
    a_frame_restart: assert property (frame_start_i |=> idx_q == 8'h00 && pos_q == 8'h00 && !stb_q) // R22
        else $error("frame start did not restart chip count");
    a_even_pair: assert property (stb_q && idx_q[0] && $past(stb_q, 2) |-> c2e == $past(c2n, 2)) // R18
        else $error("odd chip not using even second sequence");
    a_sym_hold: assert property (stb_q && pos_q != 8'h00 |-> dsym == $past(dsym, 2)) // R2
        else $error("symbol changed inside spreading period");
    a_chip_rate: assert property (stb_q |=> !stb_q) // R2
        else $error("chip strobe too fast");
    a_root_code: assert property (stb_q && cfg_q.sf_log2 == 4'h0 |-> !code_i_neg && !code_q_neg) // R7
        else $error("root code not plus one");

    c_frame_take: cover property (frame_start_i ##[1:20] bit_take_o);
    c_wrap: cover property (stb_q && idx_q == 8'hFF);
    c_gain_off: cover property (stb_q && cfg_q.gain == 4'h0 && cfg_q.en);

endmodule : return_spread_scramble

// [inc/spread_pkg.sv]
// Constants and carrier types for the return link spreading chain.
package spread_pkg;

    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_CODE = 8'h04;
    localparam logic [7:0] ADR_SCR  = 8'h08;
    localparam logic [7:0] ADR_STAT = 8'h0C;

    localparam int EN_POS   = 0;
    localparam int GAIN_POS = 4;
    localparam int SF_POS   = 8;
    localparam int KI_POS   = 0;
    localparam int KQ_POS   = 8;
    localparam int IDX_POS  = 0;
    localparam int PHS_POS  = 8;
    localparam int RUN_POS  = 16;

    localparam logic       EN_RST   = 1'b0;
    localparam logic [3:0] GAIN_RST = 4'hF;
    localparam logic [3:0] SF_RST   = 4'h0;
    localparam logic [3:0] SF_MAX   = 4'h8;
    localparam logic [7:0] K_RST    = 8'h00;
    localparam logic [23:0] NUM_RST = 24'h000000;

    localparam logic [1:0] CHIP_CLKS = 2'h2;
    localparam logic signed [5:0] AMP_FULL = 6'sh0F;
    localparam logic [7:0] IDX_LAST = 8'hFF;

    localparam int NTAPS = 9;
    localparam logic signed [7:0] RRC_TAP [NTAPS] = '{
        8'sh03, -8'sh09, -8'sh03, 8'sh29, 8'sh44, 8'sh29, -8'sh03, -8'sh09, 8'sh03
    };

    typedef struct packed {
        logic signed [5:0] re;
        logic signed [5:0] im;
    } chip_s;

    typedef struct packed {
        logic       en;
        logic [3:0] gain;
        logic [3:0] sf_log2;
    } cfg_s;

endpackage : spread_pkg

// [rtl/scramble_gen.sv]
// Short scrambling code generator with one-chip extension.
module scramble_gen (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        load_i,
    input  wire logic        step_i,
    input  wire logic        last_i,
    input  wire logic [23:0] num_i,
    output logic             c1_neg_o,
    output logic             c2_neg_o
);

    logic [1:0] a_q [8];
    logic [1:0] a_d [8];
    logic [7:0] b_q;
    logic [7:0] b_d;
    logic [7:0] d_q;
    logic [7:0] d_d;
    logic [1:0] z0_q;
    logic [1:0] z0_d;
    logic [1:0] z;

    always_comb begin
        a_d  = a_q;
        b_d  = b_q;
        d_d  = d_q;
        z0_d = z0_q;
        if (load_i) begin
            a_d[0] = {num_i[0], 1'b1}; // R12
            for (int j = 1; j < 8; j++) begin
                a_d[j] = {num_i[j], 1'b0}; // R12
            end
            b_d  = num_i[15:8]; // R10
            d_d  = num_i[23:16];
            z0_d = {num_i[0] ^ num_i[8] ^ num_i[16], 1'b1}; // R16
        end else if (step_i) begin
            for (int j = 0; j < 7; j++) begin
                a_d[j] = a_q[j + 1];
            end
            a_d[7] = 2'(3 * a_q[5] + a_q[3] + 3 * a_q[2] + 2 * a_q[1] + 3 * a_q[0]); // R13
            b_d = {b_q[7] ^ b_q[5] ^ b_q[1] ^ b_q[0], b_q[7:1]}; // R14
            d_d = {d_q[7] ^ d_q[5] ^ d_q[4] ^ d_q[0], d_q[7:1]}; // R15
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_q  <= '{default: 2'h0};
            b_q  <= 8'h00;
            d_q  <= 8'h00;
            z0_q <= 2'h0;
        end else begin
            a_q  <= a_d;
            b_q  <= b_d;
            d_q  <= d_d;
            z0_q <= z0_d;
        end
    end

    assign z = last_i ? z0_q : {a_q[0][1] ^ b_q[0] ^ d_q[0], a_q[0][0]}; // R11 R16
    assign c1_neg_o = z[1] ^ z[0]; // R17
    assign c2_neg_o = z[1]; // R17

endmodule : scramble_gen

// [rtl/rrc_shaper.sv]
// Root raised cosine pulse shaper at two samples per chip.
module rrc_shaper (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  en_i,
    input  wire spread_pkg::chip_s     chip_i,
    output logic signed [15:0]         i_o,
    output logic signed [15:0]         q_o,
    output logic                       valid_o
);

    spread_pkg::chip_s sh_q [spread_pkg::NTAPS];
    logic signed [13:0] pr [spread_pkg::NTAPS];
    logic signed [13:0] pi [spread_pkg::NTAPS];
    logic signed [15:0] sr;
    logic signed [15:0] si;

    for (genvar t = 0; t < spread_pkg::NTAPS; t++) begin : g_tap
        assign pr[t] = sh_q[t].re * spread_pkg::RRC_TAP[t]; // R20
        assign pi[t] = sh_q[t].im * spread_pkg::RRC_TAP[t]; // R20
    end

    always_comb begin
        sr = 16'sh0000;
        si = 16'sh0000;
        for (int t = 0; t < spread_pkg::NTAPS; t++) begin
            sr = sr + 16'(pr[t]);
            si = si + 16'(pi[t]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sh_q    <= '{default: '0};
            i_o     <= 16'sh0000;
            q_o     <= 16'sh0000;
            valid_o <= 1'b0;
        end else begin
            sh_q[0] <= chip_i;
            for (int t = 1; t < spread_pkg::NTAPS; t++) begin
                sh_q[t] <= sh_q[t - 1];
            end
            i_o     <= sr; // R19
            q_o     <= si; // R19
            valid_o <= en_i;
        end
    end

endmodule : rrc_shaper

// [tb/tx_sink.sv]
// Receiving end of the shaped sample stream, standing in for the up-converter.
module tx_sink (
    input  wire logic               clk_i,
    input  wire logic               rec_i,
    input  wire logic signed [15:0] tx_i_i,
    input  wire logic signed [15:0] tx_q_i,
    input  wire logic               valid_i
);
    timeunit 1ns;
    timeprecision 100ps;

    logic signed [15:0] si [$];
    logic signed [15:0] sq [$];

    // A sample not flagged valid is stored as a value no chip can produce.
    always @(posedge clk_i) begin
        if (rec_i) begin
            si.push_back(valid_i === 1'b1 ? tx_i_i : 16'h7FFF);
            sq.push_back(valid_i === 1'b1 ? tx_q_i : 16'h7FFF);
        end
    end
endmodule : tx_sink

// [tb/tb.sv]
// Self-checking bench for the spreading and scrambling chain.
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int NS = 560;
    logic        clk_i;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic        wb_ack_o, bit_take_o, tx_valid_o;
    logic        frame_start_i = 1'b0, data_bit_i = 1'b0, ctrl_bit_i = 1'b0, run = 1'b0;
    logic signed [15:0] tx_i_o, tx_q_o;
    logic        dbits [320];
    logic        cbits [320];
    int          errors, checks_done, seed, ncyc, sym, lg, g, ki, kq, best, bm, bo, e;
    int          c1 [256];
    int          c2 [256];
    int          chr [$];
    int          chq [$];
    int          cf_sf [5] = '{0, 2, 3, 15, 1};
    int          cf_g [5] = '{15, 7, 0, 1, 15};
    int          cf_ki [5] = '{0, 3, 5, 200, 1};
    int          cf_kq [5] = '{0, 1, 6, 77, 0};
    logic [23:0] num;

    return_spread_scramble i_return_spread_scramble (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .frame_start_i(frame_start_i), .data_bit_i(data_bit_i),
        .ctrl_bit_i(ctrl_bit_i), .bit_take_o(bit_take_o), .tx_i_o(tx_i_o), .tx_q_o(tx_q_o),
        .tx_valid_o(tx_valid_o)
    );

    tx_sink i_tx_sink (
        .clk_i(clk_i), .rec_i(run), .tx_i_i(tx_i_o), .tx_q_i(tx_q_o), .valid_i(tx_valid_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        if (errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    // One classic bus cycle, held until the acknowledge is sampled.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        // A slave that never answers is caught by the watchdog.
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    ////////////////////////////////////////////////////////////////////////////////
    task automatic gen_scr(input logic [23:0] n);
        int a [255];
        int b [255];
        int d [255];
        int z;
        for (int i = 0; i < 8; i++) begin
            a[i] = (2 * int'(n[i]) + (i == 0)) % 4;
            b[i] = int'(n[8 + i]);
            d[i] = int'(n[16 + i]);
        end
        for (int i = 8; i < 255; i++) begin
            a[i] = (3 * a[i-3] + a[i-5] + 3 * a[i-6] + 2 * a[i-7] + 3 * a[i-8]) % 4;
            b[i] = (b[i-1] + b[i-3] + b[i-7] + b[i-8]) % 2;
            d[i] = (d[i-1] + d[i-3] + d[i-4] + d[i-8]) % 2;
        end
        for (int i = 0; i < 255; i++) begin
            z = (a[i] + 2 * b[i] + 2 * d[i]) % 4;
            c1[i] = (z == 1 || z == 2) ? -1 : 1;
            c2[i] = (z >= 2) ? -1 : 1;
        end
        c1[255] = c1[0];
        c2[255] = c2[0];
    endtask : gen_scr

    function automatic int orthogonal_tree_code(int l, int k, int p);
        int h, c;
        if (l == 0) return 1;
        h = 1 << (l - 1);
        c = orthogonal_tree_code(l - 1, k >> 1, p % h);
        return (p >= h && k % 2 == 1) ? -c : c;
    endfunction : orthogonal_tree_code

    function automatic int ex(int mode, int off, int n, bit im);
        int acc, m;
        acc = 0;
        for (int t = 0; t < spread_pkg::NTAPS; t++) begin
            m = n - off - t - 3;
            if (m >= 0 && (mode == 1 || m % 2 == 0)) acc += spread_pkg::RRC_TAP[t] * (im ? chq[m/2] : chr[m/2]);
        end
        return acc;
    endfunction : ex

    // Feeds one bit pair per take strobe and times the strobes from frame start.
    always @(posedge clk_i) begin
        if (run) begin
            ncyc = ncyc + 1;
            if (bit_take_o === 1'b1) begin
                check(ncyc, 3 + sym * (2 << lg));
                sym = sym + 1;
            end
        end
        data_bit_i <= dbits[sym];
        ctrl_bit_i <= cbits[sym];
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        errors = errors + 1;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int s, w, i, vi, vq, msk;
        seed = 32'h3136;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, spread_pkg::ADR_CTRL, 32'h0, 4'hF);
        check(q, (32'(spread_pkg::SF_RST) << 8) | (32'(spread_pkg::GAIN_RST) << 4) | 32'(spread_pkg::EN_RST));
        wb(1'b0, spread_pkg::ADR_CODE, 32'h0, 4'hF);
        check(q, 32'h0);
        wb(1'b1, 8'h10, 32'hFFFFFFFF, 4'hF);
        wb(1'b0, 8'h10, 32'h0, 4'hF);
        check(q, 32'h0);
        for (int c = 0; c < 5; c++) begin
            lg = cf_sf[c] > 8 ? 8 : cf_sf[c];
            g = cf_g[c];
            ki = cf_ki[c];
            kq = cf_kq[c];
            num = (c == 0) ? 24'h000001 : (c == 3) ? 24'hFFFFFF : 24'($random(seed));
            @(posedge clk_i);
            frame_start_i <= 1'b1;
            wb(1'b1, spread_pkg::ADR_CTRL, 32'h0, 4'hF);
            repeat (12) @(posedge clk_i);
            wb(1'b1, spread_pkg::ADR_CODE, 32'((kq << 8) | ki), 4'h3);
            wb(1'b1, spread_pkg::ADR_SCR, {8'hA5, num}, 4'h7);
            wb(1'b0, spread_pkg::ADR_SCR, 32'h0, 4'hF);
            check(q, {8'h00, num});
            wb(1'b1, spread_pkg::ADR_CTRL, 32'((cf_sf[c] << 8) | (g << 4) | 1), 4'h3);
            wb(1'b0, spread_pkg::ADR_CTRL, 32'h0, 4'hF);
            check(q, 32'((lg << 8) | (g << 4) | 1));
            wb(1'b0, spread_pkg::ADR_STAT, 32'h0, 4'hF);
            check(q, 32'h1 << spread_pkg::RUN_POS);
            for (int k = 0; k < 320; k++) begin
                dbits[k] = 1'($random(seed));
                cbits[k] = 1'($random(seed));
            end
            gen_scr(num);
            chr.delete();
            chq.delete();
            msk = (1 << lg) - 1;
            for (int k = 0; k < 300; k++) begin
                vi = (dbits[k >> lg] ? -15 : 15) * orthogonal_tree_code(lg, ki & msk, k & msk);
                vq = (cbits[k >> lg] ? -g : g) * orthogonal_tree_code(lg, kq & msk, k & msk);
                i = k % 256;
                s = c1[i] * c2[i - i % 2];
                w = (i % 2 == 1) ? -1 : 1;
                chr.push_back(s * (vi - w * vq));
                chq.push_back(s * (vq + w * vi));
            end
            sym = 0;
            ncyc = 0;
            i_tx_sink.si.delete();
            i_tx_sink.sq.delete();
            @(posedge clk_i);
            frame_start_i <= 1'b0;
            run <= 1'b1;
            repeat (NS) @(posedge clk_i);
            run <= 1'b0;
            // Let the last recorded edge settle before the queues and counts are read.
            @(posedge clk_i);
            check(sym, (NS - 3) / (2 << lg) + 1);
            best = -1;
            for (int md = 0; md < 2; md++) begin
                for (int off = 0; off < 9; off++) begin
                    e = 0;
                    for (int n = 1; n <= NS; n++) begin
                        if (ex(md, off, n, 0) != i_tx_sink.si[n-1] || ex(md, off, n, 1) != i_tx_sink.sq[n-1]) e++;
                    end
                    if (best < 0 || e < best) begin
                        best = e;
                        bm = md;
                        bo = off;
                    end
                end
            end
            for (int n = 1; n <= NS; n++) begin
                check(i_tx_sink.si[n-1], ex(bm, bo, n, 0));
                check(i_tx_sink.sq[n-1], ex(bm, bo, n, 1));
            end
        end
        stop_test();
    end
endmodule : tb
